// ==== src/rsa_top.sv ====
`timescale 1ns/10ps
module rsa_top
#(
    parameter int STAB_CYCLES = rsa_pkg::STAB_CYCLES
)
(
    input  wire logic                         MCLK,
    input  wire logic                         RSTN,
    input  wire logic [rsa_pkg::ADDR_W-1:0]   HOST_ADDRESS_BUS,
    input  wire logic                         CE_N,
    input  wire logic                         OE_N,
    input  wire logic                         WE_N,
    input  wire logic [rsa_pkg::DATA_W-1:0]   BYTE_DATA_BUS_IN,
    output logic      [rsa_pkg::DATA_W-1:0]   BYTE_DATA_BUS_OUT,
    output logic                              BYTE_DATA_BUS_OE,
    output logic                              RAM_CHIP_SELECT_OUT_N,
    output logic                              RAM_OUTPUT_ENABLE_OUT_N,
    input  wire logic                         SUPPLY_OK,
    input  wire logic                         CRYSTAL_INPUT,
    input  wire logic                         ALARM_EVENT,
    input  wire logic                         FREQ_TEST_SELECT,
    output logic                              ALARM_IRQ_FREQ_TEST_OUT_O,
    output logic                              ALARM_IRQ_FREQ_TEST_OUT_OE,
    output logic                              RESET_OUT_O,
    output logic                              RESET_OUT_OE
);
    rsa_bus_if bus ();

    rsa_decode u_decode
    (
        .addr (HOST_ADDRESS_BUS),
        .bus  (bus)
    );

    logic [rsa_pkg::DATA_W-1:0]     regs [rsa_pkg::NUM_REGS];
    logic [rsa_pkg::DATA_W-1:0]     next_regs [rsa_pkg::NUM_REGS];
    logic [rsa_pkg::STAB_CNT_W-1:0] stab_cnt;
    logic [rsa_pkg::STAB_CNT_W-1:0] next_stab_cnt;
    logic                           rst_active;
    logic                           next_rst_active;
    logic                           xtal_prev;
    logic                           next_xtal_prev;
    logic                           tick;
    logic                           we_prev;
    logic                           next_we_prev;
    logic                           write_edge;
    logic [rsa_pkg::DATA_W-1:0]     rd_byte;

    // Reset output: any supply dip restarts the settling count
    always_comb
    begin
        next_stab_cnt = stab_cnt;
        next_rst_active = rst_active;
        if (!SUPPLY_OK)
        begin
            next_stab_cnt = rsa_pkg::CNT_ZERO;
            next_rst_active = 1'b1;
        end
        else if (rst_active)
        begin
            if (stab_cnt >= STAB_CYCLES - 1)
                next_rst_active = 1'b0;
            else
                next_stab_cnt = stab_cnt + rsa_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            stab_cnt <= rsa_pkg::CNT_ZERO;
            rst_active <= 1'b1;
        end
        else
        begin
            stab_cnt <= next_stab_cnt;
            rst_active <= next_rst_active;
        end
    end

    // Access gating shared by register and RAM paths
    assign bus.access_ok = !rst_active && SUPPLY_OK;

    // Enable steering stays combinational so only propagation delay is added
    always_comb
    begin
        RAM_CHIP_SELECT_OUT_N = 1'b1;
        RAM_OUTPUT_ENABLE_OUT_N = 1'b1;
        if (bus.access_ok && !bus.hit)
        begin
            RAM_CHIP_SELECT_OUT_N = CE_N;
            RAM_OUTPUT_ENABLE_OUT_N = OE_N;
        end
    end

    // Time base: every 32768th rising edge of the 32.768kHz input advances the seconds byte
    always_comb
    begin
        next_xtal_prev = CRYSTAL_INPUT;
        tick = CRYSTAL_INPUT && !xtal_prev;
        next_we_prev = WE_N;
        write_edge = !WE_N && we_prev && !CE_N && bus.hit && bus.access_ok;
    end

    // Register file; a host write to the seconds byte wins over the tick
    logic [rsa_pkg::FRAC_W-1:0]     frac;
    logic [rsa_pkg::FRAC_W-1:0]     next_frac;
    always_comb
    begin
        next_frac = frac;
        for (int i = 0; i < rsa_pkg::NUM_REGS; i++)
            next_regs[i] = regs[i];
        if (tick)
        begin
            next_frac = frac + rsa_pkg::FRAC_ONE;
            if (frac == rsa_pkg::FRAC_LAST)
            begin
                if (regs[rsa_pkg::SECS_REG] >= rsa_pkg::SECS_MAX)
                    next_regs[rsa_pkg::SECS_REG] = rsa_pkg::REG_RESET;
                else
                    next_regs[rsa_pkg::SECS_REG] = regs[rsa_pkg::SECS_REG] + rsa_pkg::BYTE_ONE;
            end
        end
        if (write_edge)
            next_regs[bus.sel] = BYTE_DATA_BUS_IN;
    end

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            xtal_prev <= 1'b0;
            we_prev <= 1'b1;
            frac <= rsa_pkg::FRAC_ZERO;
            for (int i = 0; i < rsa_pkg::NUM_REGS; i++)
                regs[i] <= rsa_pkg::REG_RESET;
        end
        else
        begin
            xtal_prev <= next_xtal_prev;
            we_prev <= next_we_prev;
            frac <= next_frac;
            for (int i = 0; i < rsa_pkg::NUM_REGS; i++)
                regs[i] <= next_regs[i];
        end
    end

    // Read path is combinational so the host sees ripple-through data
    always_comb
    begin
        rd_byte = regs[bus.sel];
        BYTE_DATA_BUS_OUT = rd_byte;
        BYTE_DATA_BUS_OE = bus.hit && !CE_N && !OE_N && WE_N && bus.access_ok;
    end

    // Open-drain outputs: drive low only
    always_comb
    begin
        ALARM_IRQ_FREQ_TEST_OUT_O = 1'b0;
        if (FREQ_TEST_SELECT)
            ALARM_IRQ_FREQ_TEST_OUT_OE = CRYSTAL_INPUT;
        else
            ALARM_IRQ_FREQ_TEST_OUT_OE = ALARM_EVENT;
        RESET_OUT_O = 1'b0;
        RESET_OUT_OE = rst_active;
    end

    a_ram_blocked_hit : assert property (@(posedge MCLK) disable iff (!RSTN)
        bus.hit |-> RAM_CHIP_SELECT_OUT_N && RAM_OUTPUT_ENABLE_OUT_N)
        else $error("RAM enabled during window hit");
    a_ram_pass_through : assert property (@(posedge MCLK) disable iff (!RSTN)
        (!bus.hit && bus.access_ok) |-> RAM_CHIP_SELECT_OUT_N == CE_N
            && RAM_OUTPUT_ENABLE_OUT_N == OE_N)
        else $error("RAM enables not passed through");
    a_cs_follows : assert property (@(posedge MCLK) disable iff (!RSTN)
        (!bus.hit && bus.access_ok && !CE_N) |-> !RAM_CHIP_SELECT_OUT_N)
        else $error("RAM chip select not following host");
    a_read_drive : assert property (@(posedge MCLK) disable iff (!RSTN)
        (bus.hit && !CE_N && !OE_N && WE_N && bus.access_ok)
            |-> BYTE_DATA_BUS_OE && BYTE_DATA_BUS_OUT == regs[bus.sel])
        else $error("Register read not driven");
    a_write_store : assert property (@(posedge MCLK) disable iff (!RSTN)
        (write_edge && bus.sel != rsa_pkg::SECS_REG)
            |=> regs[$past(bus.sel)] == $past(BYTE_DATA_BUS_IN))
        else $error("Register write lost");
    a_reset_blocks : assert property (@(posedge MCLK) disable iff (!RSTN)
        rst_active |-> RAM_CHIP_SELECT_OUT_N && !BYTE_DATA_BUS_OE && !write_edge)
        else $error("Access during reset");
    a_supply_reset : assert property (@(posedge MCLK) disable iff (!RSTN)
        !SUPPLY_OK |=> RESET_OUT_OE && stab_cnt == rsa_pkg::CNT_ZERO)
        else $error("Reset not asserted on low supply");
    a_supply_inhibit : assert property (@(posedge MCLK) disable iff (!RSTN)
        !SUPPLY_OK |-> !bus.access_ok && RAM_CHIP_SELECT_OUT_N)
        else $error("Access on low supply");
    a_irq_select : assert property (@(posedge MCLK) disable iff (!RSTN)
        ALARM_IRQ_FREQ_TEST_OUT_OE == (FREQ_TEST_SELECT ? CRYSTAL_INPUT : ALARM_EVENT))
        else $error("Interrupt pin source wrong");
    a_tick_count : assert property (@(posedge MCLK) disable iff (!RSTN)
        tick |=> frac == $past(frac) + rsa_pkg::FRAC_ONE)
        else $error("Time base tick missed");

    // A write starts on the strobe fall inside the window while access is allowed
    sequence s_write_strobe;
        !WE_N && we_prev && !CE_N && bus.hit && bus.access_ok;
    endsequence

    // Release must follow a full settling count, never a partial one
    sequence s_reset_release;
        rst_active ##1 !rst_active;
    endsequence

    a_write_landed : assert property (@(posedge MCLK) disable iff (!RSTN)
        s_write_strobe |=> regs[$past(bus.sel)] == $past(BYTE_DATA_BUS_IN))
        else $error("Strobed byte not stored");
    a_reset_hold : assert property (@(posedge MCLK) disable iff (!RSTN)
        s_reset_release |-> $past(stab_cnt) == STAB_CYCLES - 1)
        else $error("Reset released early");
    a_bus_quiet : assert property (@(posedge MCLK) disable iff (!RSTN)
        !bus.hit |-> !BYTE_DATA_BUS_OE)
        else $error("Data bus driven outside window");
    a_write_blocked : assert property (@(posedge MCLK) disable iff (!RSTN)
        (!SUPPLY_OK || rst_active) |-> !write_edge && RAM_OUTPUT_ENABLE_OUT_N)
        else $error("Write or RAM access while blocked");
endmodule // rsa_top

// ==== src/rsa_pkg.sv ====
package rsa_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int REG_SEL_W = 4;
    localparam int NUM_REGS = 16;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam int CLK_HZ = 25000000;
    localparam int STAB_MS = 200;
    localparam int STAB_CYCLES = (CLK_HZ / 1000) * STAB_MS;
    localparam int STAB_CNT_W = 32;
    localparam logic [STAB_CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic [STAB_CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam int TICK_HZ = 32768;
    localparam int FRAC_W = 15;
    localparam logic [FRAC_W-1:0] FRAC_ZERO = 15'h0000;
    localparam logic [FRAC_W-1:0] FRAC_ONE = 15'h0001;
    localparam logic [FRAC_W-1:0] FRAC_LAST = 15'h7fff;
    localparam logic [DATA_W-1:0] SECS_MAX = 8'h3b;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [REG_SEL_W-1:0] SECS_REG = 4'hf;
    typedef enum logic [0:0] {IRQ_ALARM, IRQ_FREQ_TEST} rsa_irq_sel_type;
endpackage

// ==== src/rsa_bus_if.sv ====
`timescale 1ns/10ps
interface rsa_bus_if;
    logic                              hit;
    logic [rsa_pkg::REG_SEL_W-1:0]     sel;
    logic                              access_ok;
    modport decoder (output hit, output sel, input access_ok);
    modport user (input hit, input sel, output access_ok);
endinterface

// ==== src/rsa_decode.sv ====
`timescale 1ns/10ps
module rsa_decode
(
    input  wire logic [rsa_pkg::ADDR_W-1:0] addr,
    rsa_bus_if.decoder                      bus
);
    // Upper bits all high selects the window; the low nibble picks the register
    assign bus.hit = &addr[rsa_pkg::ADDR_W-1:rsa_pkg::REG_SEL_W];
    assign bus.sel = addr[rsa_pkg::REG_SEL_W-1:0];
endmodule // rsa_decode

// ==== verification/rsa_ram_model.sv ====
`timescale 1ns/10ps
module rsa_ram_model
(
    input  wire logic clk,
    input  wire logic cs_n,
    input  wire logic oe_n,
    output int        reads
);
    int cnt = 0;
    assign reads = cnt;
    // The far RAM only answers a read when both of its enables are low
    always @(posedge clk)
    begin
        if (!cs_n && !oe_n)
        begin
            cnt <= cnt + 1;
        end
    end
endmodule // rsa_ram_model

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    localparam int STAB = 20;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [18:0] addr = 19'h00000;
    logic        ce = 1'b1, oe = 1'b1, we = 1'b1, supply = 1'b1;
    logic        crys = 1'b0, alarm = 1'b0, ftsel = 1'b0, probe = 1'b0, blk = 1'b1;
    logic [7:0]  din = 8'h00, bout;
    logic        boe, rcs_n, roe_n, irq_o, irq_oe, rst_o, rst_oe;
    logic [14:0] q[$];
    logic [7:0]  mirror[16];
    int          fail_count = 0, checks_done = 0, ram_reads, base, want;
    rsa_top #(.STAB_CYCLES(STAB)) u_dut
    (
        .MCLK(mclk), .RSTN(rstn), .HOST_ADDRESS_BUS(addr), .CE_N(ce), .OE_N(oe),
        .WE_N(we), .BYTE_DATA_BUS_IN(din), .BYTE_DATA_BUS_OUT(bout),
        .BYTE_DATA_BUS_OE(boe), .RAM_CHIP_SELECT_OUT_N(rcs_n),
        .RAM_OUTPUT_ENABLE_OUT_N(roe_n), .SUPPLY_OK(supply), .CRYSTAL_INPUT(crys),
        .ALARM_EVENT(alarm), .FREQ_TEST_SELECT(ftsel), .ALARM_IRQ_FREQ_TEST_OUT_O(irq_o),
        .ALARM_IRQ_FREQ_TEST_OUT_OE(irq_oe), .RESET_OUT_O(rst_o), .RESET_OUT_OE(rst_oe)
    );
    rsa_ram_model u_ram (.clk(mclk), .cs_n(rcs_n), .oe_n(roe_n), .reads(ram_reads));
    initial
    begin
        forever #20 mclk = ~mclk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic compare(input logic [14:0] got, input logic [14:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus state per cycle; the expected port picture is queued for the watcher
    task automatic step(input logic [18:0] a, input logic c, o, w, input logic [7:0] d);
        logic [2:0] r;
        logic       h;
        logic       bo;
        r = 3'($urandom);
        h = &a[18:4];
        bo = !blk && h && !c && !o && w;
        @(posedge mclk);
        {addr, ce, oe, we, din, alarm, ftsel, crys} <= {a, c, o, w, d, r};
        probe <= 1'b1;
        q.push_back({1'b0, r[1] ? r[0] : r[2], 1'b0, blk, bo,
                     bo ? mirror[a[3:0]] : 8'h00, blk | h | c, blk | h | o});
        if (!blk && h && !c && !w)
            mirror[a[3:0]] = d;
    endtask
    task automatic idle();
        @(posedge mclk);
        {ce, oe, we, probe} <= 4'b1110;
    endtask
    task automatic wait_rst();
        int n;
        n = 0;
        // Look just after each edge so the registered reset output has settled
        do
        begin
            idle();
            #1;
            n++;
        end
        while (rst_oe !== 1'b0 && n < 200);
        compare(15'(n), 15'(STAB));
        blk = 1'b0;
    endtask
    always @(negedge mclk)
    begin
        if (probe)
            compare({irq_o, irq_oe, rst_o, rst_oe, boe, boe ? bout : 8'h00, rcs_n, roe_n},
                    q.pop_front());
    end
    initial
    begin
        #(40 * 20000);
        fail_count++;
        wrap_up();
    end
    initial
    begin
        base = int'($urandom(32'h7c54));
        repeat (13) idle();
        step(19'h7fff3, 1'b0, 1'b0, 1'b1, 8'h00);
        step(19'h00123, 1'b0, 1'b0, 1'b1, 8'h00);
        idle();
        rstn <= 1'b1;
        wait_rst();
        $display("test reset done");
        base = ram_reads;
        want = 0;
        for (int i = 0; i < 8; i++)
        begin
            step(19'($urandom) & 19'h7ffef, i[0], i[1], i[2], 8'($urandom));
            want += int'(i[1:0] == 2'b00);
        end
        idle();
        compare(15'(ram_reads - base), 15'(want));
        $display("test pass-through done");
        for (int r = 0; r < 16; r++)
        begin
            base = int'($urandom);
            step({15'h7fff, 4'(r)}, 1'b0, 1'b1, 1'b1, 8'(base));
            step({15'h7fff, 4'(r)}, 1'b0, 1'b1, 1'b0, 8'(base));
            step({15'h7fff, 4'(r)}, 1'b1, 1'b1, 1'b1, 8'(base));
            step({15'h7fff, 4'(r)}, 1'b0, 1'b0, 1'b1, 8'h00);
            step({15'h7fff, 4'(r)}, 1'b0, 1'b1, 1'b1, 8'h00);
        end
        $display("test window done");
        idle();
        supply <= 1'b0;
        idle();
        idle();
        blk = 1'b1;
        step(19'h7fff2, 1'b0, 1'b1, 1'b0, ~mirror[2]);
        step(19'h7fff2, 1'b0, 1'b0, 1'b1, 8'h00);
        step(19'h00040, 1'b0, 1'b0, 1'b1, 8'h00);
        idle();
        supply <= 1'b1;
        wait_rst();
        step(19'h7fff2, 1'b0, 1'b0, 1'b1, 8'h00);
        idle();
        $display("test supply done");
        wrap_up();
    end
endmodule // testbench
